// [pkg/chopper_pkg.sv]
// Overview of operation
// - A comparator report of current above the high threshold starts the blanking count at once.
// - Current still above the high threshold when blanking expires raises current limit.
// - Raising current limit turns both low sides on and starts the minimum off count.
// - When the off count ends with current below the low threshold, drive follows the pulse input.
// - While the off count runs, a high pulse input is ignored and the brake is kept.
// - Current above the low threshold when the off count ends keeps the brake applied.
// - Current later reported below the low threshold clears current limit and resumes drive.
// - A low pulse input during blanking applies the brake at once.
// - Outside current limit, a low pulse input brakes and a high one drives.
// - Per channel, the high threshold is 6.5 A or 4.6 A and hysteresis 0.25 A or 0.5 A.
// - Combined mode totals 13 A or 9.2 A with 0.5 A or 1.0 A hysteresis.
// - A thermal warning forces a 2.5 A high threshold and lowers the low threshold with it.
// - Current monitoring stays on while outputs are off and stops only in sleep.
package chopper_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int BLANK_NS = 11500;
  localparam int TOFF_NS = 20500;
  // Least times, rounded up to whole cycles
  localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TOFF_CYC = (TOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam int NCH = 2;

  // Threshold codes in steps of 50 mA
  localparam int THR_W = 10;
  localparam int LSB_MA = 50;
  localparam logic [THR_W-1:0] HIGH_STD = THR_W'(6500 / LSB_MA);
  localparam logic [THR_W-1:0] HIGH_RED = THR_W'(4600 / LSB_MA);
  localparam logic [THR_W-1:0] HIGH_THERM = THR_W'(2500 / LSB_MA);
  localparam logic [THR_W-1:0] HYST_SMALL = THR_W'(250 / LSB_MA);
  localparam logic [THR_W-1:0] HYST_LARGE = THR_W'(500 / LSB_MA);

  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADR_W-1:0] CH0_THR_OFS = 8'h08;
  localparam logic [ADR_W-1:0] CH1_THR_OFS = 8'h0c;
  localparam logic [ADR_W-1:0] TOTAL_THR_OFS = 8'h10;

  // Control: bit 2*ch selects 4.6 A, bit 2*ch+1 selects 0.5 A hysteresis
  localparam int CTRL_W = 5;
  localparam int CTRL_COMBINED_BIT = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam int STAT_LIMIT_LSB = 0;
  localparam int STAT_BRAKE_LSB = 2;
  localparam int STAT_THERM_BIT = 4;
  localparam int STAT_MON_BIT = 5;
  localparam int THR_LOW_LSB = 16;

  typedef struct packed {
    logic [THR_W-1:0] high;
    logic [THR_W-1:0] low;
  } limit_cfg_t;

  typedef struct packed {
    logic above_high;
    logic below_low;
    logic pulse;
  } ch_sense_t;

  typedef struct packed {
    logic limit;
    logic brake;
  } ch_drive_t;

  typedef enum {ST_DRIVE, ST_BLANK, ST_OFF, ST_HOLD} chop_state_t;
endpackage

// [design/sync2.sv]
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  import chopper_pkg::*;
  logic [W-1:0] meta_reg;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// [design/chop_channel.sv]
`timescale 1ns/100ps
`default_nettype none
module chop_channel (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Comparators and pulse input
  input wire chopper_pkg::ch_sense_t sense,
  // Bridge control
  output chopper_pkg::ch_drive_t drive
);
  import chopper_pkg::*;
  chop_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_DRIVE: begin
        if (sense.above_high) begin
          state_next = ST_BLANK;
        end
      end
      ST_BLANK: begin
        if (!sense.above_high) begin
          state_next = ST_DRIVE;
        end else if (cnt_reg == CNT_W'(BLANK_CYC - 1)) begin
          state_next = ST_OFF;
        end
      end
      ST_OFF: begin
        if (cnt_reg == CNT_W'(TOFF_CYC - 1)) begin
          state_next = sense.below_low ? ST_DRIVE : ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (sense.below_low) begin
          state_next = ST_DRIVE;
        end
      end
      default: state_next = ST_DRIVE;
    endcase
  end

  // Count restarts on every state change
  always_comb begin
    cnt_next = (state_next == state_reg) ? cnt_reg + CNT_W'(1) : '0;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_DRIVE;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // Limit overrides the pulse input; blanking still follows it
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive <= '{limit: 1'b0, brake: 1'b1};
    end else begin
      drive.limit <= (state_next == ST_OFF) || (state_next == ST_HOLD);
      drive.brake <= (state_next == ST_OFF) || (state_next == ST_HOLD)
        || !sense.pulse;
    end
  end
endmodule
`default_nettype wire

// [design/chopper_current_limit_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
module chopper_current_limit_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [chopper_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins and comparators
  input wire logic [chopper_pkg::NCH-1:0] drive_pulse_input,
  input wire logic [chopper_pkg::NCH-1:0] above_high_in,
  input wire logic [chopper_pkg::NCH-1:0] below_low_in,
  input wire logic thermal_warn_in,
  input wire logic sleep_select_n,
  // Bridge and analog control
  output logic [chopper_pkg::NCH-1:0] brake_low_sides,
  output logic [chopper_pkg::NCH-1:0] current_limit,
  output chopper_pkg::limit_cfg_t [chopper_pkg::NCH-1:0] thr_cfg,
  output logic monitor_enable
);
  import chopper_pkg::*;

  logic [NCH-1:0] pulse_s, above_s, below_s;
  logic thermal_s, sleep_n_s;
  logic [CTRL_W-1:0] ctrl_reg;
  logic combined;
  limit_cfg_t [NCH-1:0] cfg_next;
  ch_drive_t [NCH-1:0] ch_drive;
  logic [31:0] rd_mux;
  logic bus_req;

  sync2 #(
    .W(3 * NCH + 2)
  ) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in({drive_pulse_input, above_high_in, below_low_in,
      thermal_warn_in, sleep_select_n}),
    .sync_out({pulse_s, above_s, below_s, thermal_s, sleep_n_s})
  );

  assign combined = ctrl_reg[CTRL_COMBINED_BIT];

  // Combined mode drives both channels from the first channel's settings
  generate
    for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic thr_sel, hys_sel;
      logic [THR_W-1:0] high;
      assign thr_sel = combined ? ctrl_reg[0] : ctrl_reg[2*i];
      assign hys_sel = combined ? ctrl_reg[1] : ctrl_reg[2*i+1];
      assign high = thermal_s ? HIGH_THERM
        : (thr_sel ? HIGH_RED : HIGH_STD);
      assign cfg_next[i].high = high;
      assign cfg_next[i].low = high - (hys_sel ? HYST_LARGE : HYST_SMALL);

      chop_channel u_chan (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .sense('{above_high: above_s[i], below_low: below_s[i],
          pulse: pulse_s[i]}),
        .drive(ch_drive[i])
      );

      assign brake_low_sides[i] = ch_drive[i].brake;
      assign current_limit[i] = ch_drive[i].limit;
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int k = 0; k < NCH; k++) begin
        thr_cfg[k] <= '{high: HIGH_STD, low: HIGH_STD - HYST_SMALL};
      end
    end else begin
      thr_cfg <= cfg_next;
    end
  end

  // Monitor ignores enables; only sleep stops it
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      monitor_enable <= 1'b0;
    end else begin
      monitor_enable <= sleep_n_s;
    end
  end

  // Answer one cycle after the request; write lands at the ack edge
  assign bus_req = wb_cyc_i && wb_stb_i;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RST;
    end else if (bus_req && wb_we_i && wb_ack_o && wb_adr_i == CTRL_OFS
        && wb_sel_i[0]) begin
      ctrl_reg <= wb_dat_i[CTRL_W-1:0];
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      CTRL_OFS: rd_mux[CTRL_W-1:0] = ctrl_reg;
      STATUS_OFS: begin
        rd_mux[STAT_LIMIT_LSB +: NCH] = current_limit;
        rd_mux[STAT_BRAKE_LSB +: NCH] = brake_low_sides;
        rd_mux[STAT_THERM_BIT] = thermal_s;
        rd_mux[STAT_MON_BIT] = monitor_enable;
      end
      CH0_THR_OFS: begin
        rd_mux[THR_W-1:0] = thr_cfg[0].high;
        rd_mux[THR_LOW_LSB +: THR_W] = thr_cfg[0].low;
      end
      CH1_THR_OFS: begin
        rd_mux[THR_W-1:0] = thr_cfg[1].high;
        rd_mux[THR_LOW_LSB +: THR_W] = thr_cfg[1].low;
      end
      TOTAL_THR_OFS: begin
        if (combined) begin
          rd_mux[THR_W-1:0] = thr_cfg[0].high + thr_cfg[1].high;
          rd_mux[THR_LOW_LSB +: THR_W] = thr_cfg[0].low + thr_cfg[1].low;
        end
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Unmapped addresses still answer, reading zero
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_ack_o) begin
      wb_dat_o <= rd_mux;
    end
  end

  // Run counters watched by the checks below
  logic [CNT_W:0] above_run_reg, limit_run_reg;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      above_run_reg <= '0;
      limit_run_reg <= '0;
    end else begin
      if (!above_s[0] || current_limit[0]) begin
        above_run_reg <= '0;
      end else if (!(&above_run_reg)) begin
        above_run_reg <= above_run_reg + (CNT_W + 1)'(1);
      end
      if (!current_limit[0]) begin
        limit_run_reg <= '0;
      end else if (!(&limit_run_reg)) begin
        limit_run_reg <= limit_run_reg + (CNT_W + 1)'(1);
      end
    end
  end

  localparam int BLANK_MIN = BLANK_CYC;
  localparam int TOFF_LAST = TOFF_CYC - 1;

  property p_blank_before_limit;
    @(posedge sys_clk) disable iff (sys_rst)
      $rose(current_limit[0]) |-> above_run_reg >= (CNT_W + 1)'(BLANK_MIN);
  endproperty
  a_blank_before_limit: assert property (p_blank_before_limit)
    else $error("limit rose before blanking elapsed");

  property p_blank_cancel;
    @(posedge sys_clk) disable iff (sys_rst)
      !current_limit[0] && !above_s[0] |=> !current_limit[0];
  endproperty
  a_blank_cancel: assert property (p_blank_cancel)
    else $error("limit rose without current above high threshold");

  property p_limit_brakes;
    @(posedge sys_clk) disable iff (sys_rst)
      current_limit[0] |-> brake_low_sides[0];
  endproperty
  a_limit_brakes: assert property (p_limit_brakes)
    else $error("limit without short brake");

  property p_off_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      current_limit[0] && limit_run_reg < (CNT_W + 1)'(TOFF_LAST)
        |=> current_limit[0] && brake_low_sides[0];
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("limit ended before minimum off time");

  property p_resume;
    @(posedge sys_clk) disable iff (sys_rst)
      current_limit[0] && limit_run_reg >= (CNT_W + 1)'(TOFF_LAST) && below_s[0]
        |=> !current_limit[0];
  endproperty
  a_resume: assert property (p_resume)
    else $error("limit not released below low threshold");

  property p_keep_brake;
    @(posedge sys_clk) disable iff (sys_rst)
      current_limit[0] && !below_s[0] |=> current_limit[0];
  endproperty
  a_keep_brake: assert property (p_keep_brake)
    else $error("limit released above low threshold");

  property p_pulse_low_brakes;
    @(posedge sys_clk) disable iff (sys_rst)
      !pulse_s[0] |=> brake_low_sides[0];
  endproperty
  a_pulse_low_brakes: assert property (p_pulse_low_brakes)
    else $error("low pulse input did not brake");

  property p_pulse_high_drives;
    @(posedge sys_clk) disable iff (sys_rst)
      !current_limit[0] && $past(pulse_s[0]) |-> !brake_low_sides[0];
  endproperty
  a_pulse_high_drives: assert property (p_pulse_high_drives)
    else $error("high pulse input did not drive");

  property p_default_thr;
    @(posedge sys_clk) disable iff (sys_rst)
      !thermal_s && ctrl_reg == CTRL_RST |=> thr_cfg[1].high == HIGH_STD
        && thr_cfg[1].low == HIGH_STD - HYST_SMALL;
  endproperty
  a_default_thr: assert property (p_default_thr)
    else $error("default thresholds wrong");

  property p_combined_thr;
    @(posedge sys_clk) disable iff (sys_rst)
      combined && !thermal_s |=> thr_cfg[1] == thr_cfg[0];
  endproperty
  a_combined_thr: assert property (p_combined_thr)
    else $error("combined channels disagree");

  property p_thermal_thr;
    @(posedge sys_clk) disable iff (sys_rst)
      thermal_s |=> thr_cfg[0].high == HIGH_THERM && thr_cfg[0].low < HIGH_THERM;
  endproperty
  a_thermal_thr: assert property (p_thermal_thr)
    else $error("thermal threshold not applied");

  property p_monitor;
    @(posedge sys_clk) disable iff (sys_rst)
      sleep_n_s |=> monitor_enable;
  endproperty
  a_monitor: assert property (p_monitor)
    else $error("monitor off while awake");

  property p_ack_once;
    @(posedge sys_clk) disable iff (sys_rst)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held two cycles");

  c_limit: cover property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(current_limit[0]));
  c_hold: cover property (@(posedge sys_clk) disable iff (sys_rst)
    current_limit[0] && limit_run_reg > (CNT_W + 1)'(TOFF_CYC));
  c_blank_cancel: cover property (@(posedge sys_clk) disable iff (sys_rst)
    above_s[0] ##1 !above_s[0] && !current_limit[0]);
  c_thermal: cover property (@(posedge sys_clk) disable iff (sys_rst)
    thermal_s && current_limit[1]);
endmodule
`default_nettype wire

// [verification/host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Clock
  input wire logic sys_clk,
  // Pulse pins
  output logic [1:0] pulse
);
  // Start in brake so no drive is ever commanded before the first level
  initial pulse = 2'h0;
  // Host sets one channel's pulse level at the next rising edge, with no brake level between changes
  task automatic set_pulse(input int ch, input logic v);
    @(posedge sys_clk);
    pulse[ch] <= v;
  endtask
endmodule
`default_nettype wire

// [verification/chopper_current_limit_ctrl_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module chopper_current_limit_ctrl_tb_top;
  import chopper_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [3:0] wsel = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, monitor_enable;
  logic [1:0] pulse, brake_low_sides, current_limit;
  logic [1:0] above_high_in = 2'h0;
  logic [1:0] below_low_in = 2'h3;
  logic thermal_warn_in = 1'b0;
  logic sleep_select_n = 1'b1;
  limit_cfg_t [1:0] thr_cfg;
  int miscompares = 0;
  int n_checks = 0;
  int n, bad;
  logic [9:0] h, l;

  always #50 sys_clk = ~sys_clk;

  host_model host (.sys_clk(sys_clk), .pulse(pulse));
  chopper_current_limit_ctrl dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .drive_pulse_input(pulse),
    .above_high_in(above_high_in), .below_low_in(below_low_in),
    .thermal_warn_in(thermal_warn_in), .sleep_select_n(sleep_select_n),
    .brake_low_sides(brake_low_sides), .current_limit(current_limit), .thr_cfg(thr_cfg),
    .monitor_enable(monitor_enable));

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (e !== g) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    n_checks++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // Classic single cycle; ack sampled at the edge, then released
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= wsel;
    do begin
      @(posedge sys_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 20) begin
      miscompares++;
      final_report();
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(negedge sys_clk);
  endtask

  // Bounded wait on channel 0's limit level
  task automatic wait_lim(input logic v, input int lim);
    n = 0;
    while (current_limit[0] !== v && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= lim) begin
      miscompares++;
      final_report();
    end
  endtask

  initial begin
    cyc(3);
    chk("rst brake", 2'h3, brake_low_sides);
    chk("rst limit", 2'h0, current_limit);
    chk("rst thr0", {10'h082, 10'h07d}, thr_cfg[0]);
    chk("rst thr1", {10'h082, 10'h07d}, thr_cfg[1]);
    chk("rst mon", 1'b0, monitor_enable);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int ch = 0; ch < 2; ch++) begin
      for (int i = 0; i < 4; i++) begin
        wb(1'b1, CTRL_OFS, 32'(i << (2 * ch)));
        h = i[0] ? 10'h05c : 10'h082;
        l = h - (i[1] ? 10'h00a : 10'h005);
        wb(1'b0, ch ? CH1_THR_OFS : CH0_THR_OFS, 32'h0);
        chk("thr reg", {6'h0, l, 6'h0, h}, q);
        chk("thr pin", {h, l}, thr_cfg[ch]);
        chk("thr other", {10'h082, 10'h07d}, thr_cfg[1 - ch]);
      end
    end
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, CTRL_OFS, 32'h10 + 32'(i));
      h = i[0] ? 10'h0b8 : 10'h104;
      l = h - (i[1] ? 10'h014 : 10'h00a);
      wb(1'b0, TOTAL_THR_OFS, 32'h0);
      chk("total", {6'h0, l, 6'h0, h}, q);
    end
    wb(1'b1, 8'h20, 32'h1f);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, q);
    wb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl keep", 32'h13, q);
    // Byte lane 0 off: the settings must not move
    wsel = 4'he;
    wb(1'b1, CTRL_OFS, 32'h0);
    wsel = 4'hf;
    wb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl sel", 32'h13, q);
    wb(1'b1, CTRL_OFS, 32'h0);
    wb(1'b0, TOTAL_THR_OFS, 32'h0);
    chk("total off", 32'h0, q);
    thermal_warn_in <= 1'b1;
    cyc(6);
    chk("therm", {10'h032, 10'h02d}, thr_cfg[0]);
    wb(1'b0, STATUS_OFS, 32'h0);
    chk("status therm", 32'h3c, q);
    thermal_warn_in <= 1'b0;
    @(posedge sys_clk);
    sleep_select_n <= 1'b0;
    cyc(6);
    chk("sleep mon", 1'b0, monitor_enable);
    @(posedge sys_clk);
    sleep_select_n <= 1'b1;
    cyc(6);
    chk("wake mon", 1'b1, monitor_enable);
    host.set_pulse(0, 1'b1);
    host.set_pulse(1, 1'b1);
    cyc(6);
    chk("drive", 2'h0, brake_low_sides);
    host.set_pulse(0, 1'b0);
    cyc(6);
    chk("pulse brake", 2'h1, brake_low_sides);
    host.set_pulse(0, 1'b1);
    cyc(6);
    chk("pulse drive", 2'h0, brake_low_sides);
    // Limit entry, off time with pulse high, hold past off end
    @(posedge sys_clk);
    below_low_in <= 2'h2;
    above_high_in <= 2'h1;
    wait_lim(1'b1, 200);
    chk_rng("blank cycles", 116, 120, n);
    chk("limit brake", 2'h1, brake_low_sides);
    chk("ch1 limit", 2'h1, current_limit);
    wb(1'b0, STATUS_OFS, 32'h0);
    chk("status limit", 32'h25, q);
    above_high_in <= 2'h0;
    bad = 0;
    repeat (250) begin
      @(negedge sys_clk);
      bad += (brake_low_sides[0] !== 1'b1);
    end
    chk("off brake", 0, bad);
    chk("hold limit", 1'b1, current_limit[0]);
    @(posedge sys_clk);
    below_low_in <= 2'h3;
    wait_lim(1'b0, 10);
    chk_rng("release", 3, 5, n);
    cyc(2);
    chk("resume", 2'h0, brake_low_sides);
    // Off time with current already low
    @(posedge sys_clk);
    below_low_in <= 2'h2;
    above_high_in <= 2'h1;
    wait_lim(1'b1, 200);
    @(posedge sys_clk);
    above_high_in <= 2'h0;
    below_low_in <= 2'h3;
    wait_lim(1'b0, 300);
    chk_rng("off time", 203, 207, n);
    // Short excursion, then pulse low during blanking
    @(posedge sys_clk);
    below_low_in <= 2'h2;
    above_high_in <= 2'h1;
    cyc(60);
    @(posedge sys_clk);
    above_high_in <= 2'h0;
    cyc(200);
    chk("no limit", 2'h0, current_limit);
    @(posedge sys_clk);
    above_high_in <= 2'h1;
    cyc(30);
    host.set_pulse(0, 1'b0);
    cyc(5);
    chk("blank brake", 2'h1, brake_low_sides);
    chk("blank limit", 2'h0, current_limit);
    final_report();
  end
endmodule
`default_nettype wire
